// File: design/pig_consts.svh
// register indices, field positions, reset value and timing figures
`ifndef PIG_CONSTS_SVH
`define PIG_CONSTS_SVH

`define PIG_ADDR_W          8
`define PIG_IDX_LSB         2
`define PIG_IDX_MSB         4
`define PIG_IDX_CNT_LO      3'h0
`define PIG_IDX_CNT_HI      3'h1
`define PIG_IDX_MASK        3'h2
`define PIG_IDX_LIVE        3'h3
`define PIG_IDX_PRE_LO      3'h4
`define PIG_IDX_PRE_HI      3'h5
`define PIG_IDX_CFG         3'h6
`define PIG_IDX_EVT         3'h7

`define PIG_CFG_POL_LATCH   12
`define PIG_CFG_POL_HALT    13
`define PIG_CFG_POL_CLEAR   14

`define PIG_EXT_LATCH       0
`define PIG_EXT_HALT        1
`define PIG_EXT_CLEAR       2

`define PIG_RESET_WORD      16'h0000

`define PIG_CLK_PERIOD_NS   50
`define PIG_SHARED_RACK_CLOCK_TIMEOUT_NS 10000
`define PIG_DIR_HOLD_NS     1000000

`endif

// File: design/pig_pkg.sv
// shared types of the pulse input status and access guard
package pig_pkg;

   typedef logic [15:0] pig_word_t;

   typedef struct packed {
      logic [1:0]  ab;
      logic        step;
      logic        up;
      logic        fwd;
      logic        rev;
      logic [23:0] hold;
   } pig_quad_st_t;

   typedef struct packed {
      logic [23:0] count;
      logic [2:0]  mask;
      pig_word_t   pre_lo;
      pig_word_t   pre_hi;
      pig_word_t   cfg;
      logic [2:0]  evt;
      logic [2:0]  ext_prev;
      logic        shared_rack_clock_prev;
      logic        shared_rack_clock_seen;
      logic [15:0] shared_rack_clock_cnt;
      pig_word_t   rdata;
      logic        berr;
   } pig_top_st_t;

endpackage : pig_pkg

// File: design/pig_sync.sv
// two-flop synchroniser for a group of input pins
`timescale 1ns/1ps
module pig_sync #(
   parameter int unsigned WIDTH = 6
) (
   input  wire logic             clk_in,
   input  wire logic             reset_n_in,
   input  wire logic [WIDTH-1:0] d_in,
   output logic      [WIDTH-1:0] q_out
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } pig_sync_st_t;

   pig_sync_st_t st_q;
   pig_sync_st_t st_d;

   if (WIDTH < 1) $error("pig_sync: WIDTH must be at least 1");

   always_comb
   begin
      st_d        = st_q;
      st_d.meta   = d_in;
      st_d.stable = st_q.meta;
   end

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign q_out = st_q.stable;

   property p_sync_delay;
      @(posedge clk_in) disable iff (!reset_n_in)
      $past(reset_n_in, 2) |-> (q_out == $past(d_in, 2));
   endproperty
   a_sync_delay : assert property (p_sync_delay)
      else $error("synchronised input is not the pin two cycles back");

endmodule : pig_sync

// File: design/pig_quad.sv
// quadrature step decoder with held direction indicators
`timescale 1ns/1ps
module pig_quad #(
   parameter int unsigned HOLD_CYC = 20000
) (
   input  wire logic clk_in,
   input  wire logic reset_n_in,
   input  wire logic a_in,
   input  wire logic b_in,
   output logic      step_out,
   output logic      up_out,
   output logic      fwd_out,
   output logic      rev_out
);
   localparam logic [23:0] HOLD24 = 24'(HOLD_CYC);

   pig_pkg::pig_quad_st_t st_q;
   pig_pkg::pig_quad_st_t st_d;

   if (HOLD_CYC < 1 || HOLD_CYC > 16777215) $error("pig_quad: HOLD_CYC out of range");

   always_comb
   begin
      st_d      = st_q;
      st_d.ab   = {a_in, b_in};
      st_d.step = 1'b0;
      st_d.up   = 1'b0;
      // exactly one phase moved; a jump of both is noise and is dropped
      if (^(st_q.ab ^ {a_in, b_in}))
      begin
         st_d.step = 1'b1;
         st_d.up   = a_in ^ st_q.ab[0];  // swapping a and b flips this
      end
      if (st_d.step)
      begin
         st_d.fwd  = st_d.up;
         st_d.rev  = !st_d.up;
         st_d.hold = HOLD24;
      end
      else if (st_q.hold != 24'h00_0000)
         st_d.hold = st_q.hold - 24'h00_0001;
      else
      begin
         st_d.fwd = 1'b0;
         st_d.rev = 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign step_out = st_q.step;
   assign up_out   = st_q.up;
   assign fwd_out  = st_q.fwd;
   assign rev_out  = st_q.rev;

   property p_dir_fwd;
      @(posedge clk_in) disable iff (!reset_n_in)
      (step_out && up_out) |-> (fwd_out && !rev_out) ##1 (fwd_out || step_out);
   endproperty
   a_dir_fwd : assert property (p_dir_fwd)
      else $error("forward step did not light the forward indicator");

   property p_dir_rev;
      @(posedge clk_in) disable iff (!reset_n_in)
      ($past(reset_n_in) && $past(a_in) == $past(b_in) && a_in != b_in
         && $past(st_q.ab) == {$past(a_in), $past(b_in)} && a_in == $past(a_in))
         |=> (rev_out && !fwd_out);
   endproperty
   a_dir_rev : assert property (p_dir_rev)
      else $error("reverse sequence did not light the reverse indicator");

endmodule : pig_quad

// File: design/pig_top.sv
// pulse input status indicators, event flags and guarded register access
`timescale 1ns/1ps
`include "pig_consts.svh"
module pig_top #(
   parameter int unsigned DIR_HOLD_NS = `PIG_DIR_HOLD_NS
) (
   input  wire logic                   clk_in,
   input  wire logic                   reset_n_in,
   input  wire logic [`PIG_ADDR_W-1:0] addr_in,
   input  wire logic [15:0]            wdata_in,
   input  wire logic                   wr_in,
   input  wire logic                   rd_in,
   output logic      [15:0]            rdata_out,
   output logic                        bus_error_out,
   input  wire logic                   phase_a_in,
   input  wire logic                   phase_b_in,
   input  wire logic                   latch_in,
   input  wire logic                   halt_in,
   input  wire logic                   clear_in,
   input  wire logic                   shared_rack_clock_in,
   output logic                        fwd_led_out,
   output logic                        rev_led_out,
   output logic                        latch_led_out,
   output logic                        halt_led_out,
   output logic                        clear_led_out,
   output logic                        shared_clk_led_out,
   output logic                        irq_out
);
   localparam int unsigned DIR_HOLD_CYC = DIR_HOLD_NS / `PIG_CLK_PERIOD_NS;
   localparam int unsigned SHARED_RACK_CLOCK_CYC     = `PIG_SHARED_RACK_CLOCK_TIMEOUT_NS / `PIG_CLK_PERIOD_NS;
   localparam logic [15:0] SHARED_RACK_CLOCK_CYC16   = 16'(SHARED_RACK_CLOCK_CYC);

   if (DIR_HOLD_CYC < 1) $error("pig_top: DIR_HOLD_NS shorter than one clock");
   if (SHARED_RACK_CLOCK_CYC < 2 || SHARED_RACK_CLOCK_CYC > 65535) $error("pig_top: shared clock window out of range");

   pig_pkg::pig_top_st_t st_q;
   pig_pkg::pig_top_st_t st_d;

   logic [5:0] sync_lvl;
   logic [2:0] ext_lvl;
   logic [2:0] ext_pol;
   logic [2:0] ext_fire;
   logic       shared_rack_clock_lvl;
   logic       shared_rack_clock_edge;
   logic       halt_act;
   logic       q_step;
   logic       q_up;
   logic       q_fwd;
   logic       q_rev;
   logic       mapped;
   logic [2:0] idx;
   logic [2:0] evt_set;

   // all pins pass the same two-flop path; nothing reads the first flop
   pig_sync #(
      .WIDTH (6)
   ) u_sync (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .d_in       ({shared_rack_clock_in, clear_in, halt_in, latch_in,
                    phase_b_in, phase_a_in}),
      .q_out      (sync_lvl)
   );

   pig_quad #(
      .HOLD_CYC (DIR_HOLD_CYC)
   ) u_quad (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .a_in       (sync_lvl[0]),
      .b_in       (sync_lvl[1]),
      .step_out   (q_step),
      .up_out     (q_up),
      .fwd_out    (q_fwd),
      .rev_out    (q_rev)
   );

   assign ext_lvl  = sync_lvl[4:2];
   assign shared_rack_clock_lvl = sync_lvl[5];

   // polarity 0: rising edge / high level active; 1: falling edge / low level
   assign ext_pol  = st_q.cfg[`PIG_CFG_POL_CLEAR:`PIG_CFG_POL_LATCH];
   assign ext_fire = (ext_lvl ^ ext_pol) & ~(st_q.ext_prev ^ ext_pol);
   assign halt_act = ext_lvl[`PIG_EXT_HALT] ^ ext_pol[`PIG_EXT_HALT];

   assign shared_rack_clock_edge = shared_rack_clock_lvl != st_q.shared_rack_clock_prev;

   // byte address, word aligned; anything past word 7 is not ours
   assign idx    = addr_in[`PIG_IDX_MSB:`PIG_IDX_LSB];
   assign mapped = (addr_in[1:0] == 2'h0)
                && (addr_in[`PIG_ADDR_W-1:`PIG_IDX_MSB+1] == '0);

   // flags only latch while none are pending
   assign evt_set = (st_q.evt == 3'h0) ? ext_fire : 3'h0;

   function automatic pig_pkg::pig_word_t read_mux(
      input pig_pkg::pig_top_st_t s,
      input logic [2:0]           i,
      input logic [2:0]           lvl,
      input logic                 fwd,
      input logic                 rev
   );
      pig_pkg::pig_word_t w;
      w = `PIG_RESET_WORD;
      case (i)
         `PIG_IDX_CNT_LO : w = s.count[15:0];
         `PIG_IDX_CNT_HI : w = {8'h00, s.count[23:16]};
         `PIG_IDX_MASK   : w = {13'h0000, s.mask};
         `PIG_IDX_LIVE   : w = {10'h000, s.shared_rack_clock_seen, rev, fwd, lvl};
         `PIG_IDX_PRE_LO : w = s.pre_lo;
         `PIG_IDX_PRE_HI : w = s.pre_hi;
         `PIG_IDX_CFG    : w = s.cfg;
         default         : w = {13'h0000, s.evt};
      endcase
      return w;
   endfunction : read_mux

   always_comb
   begin
      st_d           = st_q;
      st_d.rdata     = `PIG_RESET_WORD;
      st_d.berr      = 1'b0;
      st_d.ext_prev  = ext_lvl;
      st_d.shared_rack_clock_prev = shared_rack_clock_lvl;

      // presence = an edge seen within the window; a stuck level reads as absent
      if (shared_rack_clock_edge)
      begin
         st_d.shared_rack_clock_seen = 1'b1;
         st_d.shared_rack_clock_cnt  = SHARED_RACK_CLOCK_CYC16;
      end
      else if (st_q.shared_rack_clock_cnt != 16'h0000)
         st_d.shared_rack_clock_cnt = st_q.shared_rack_clock_cnt - 16'h0001;
      else
         st_d.shared_rack_clock_seen = 1'b0;

      // position count: clear beats a step, halt freezes stepping
      if (ext_fire[`PIG_EXT_CLEAR])
         st_d.count = 24'h00_0000;
      else if (q_step && !halt_act)
         st_d.count = q_up ? st_q.count + 24'h00_0001 : st_q.count - 24'h00_0001;

      st_d.evt = st_q.evt | evt_set;

      if (wr_in)
      begin
         if (!mapped)
            st_d.berr = 1'b1;
         else
         begin
            case (idx)
               `PIG_IDX_MASK   : st_d.mask   = wdata_in[2:0];
               `PIG_IDX_PRE_LO : st_d.pre_lo = wdata_in;
               `PIG_IDX_PRE_HI : st_d.pre_hi = wdata_in;
               `PIG_IDX_CFG    : st_d.cfg    = wdata_in;
               // only flags already pending can be cleared, so a new set survives
               `PIG_IDX_EVT    : st_d.evt    = st_d.evt & ~(wdata_in[2:0] & st_q.evt);
               // counter words and live status take no data
               default         : st_d.berr   = 1'b1;
            endcase
         end
      end

      if (rd_in)
      begin
         if (!mapped)
            st_d.berr = 1'b1;
         else
         begin
            st_d.rdata = read_mux(st_q, idx, ext_lvl, q_fwd, q_rev);
            // read clears the flags it returned
            if (idx == `PIG_IDX_EVT)
               st_d.evt = st_d.evt & ~st_q.evt;
         end
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign rdata_out          = st_q.rdata;
   assign bus_error_out      = st_q.berr;
   assign fwd_led_out        = q_fwd;
   assign rev_led_out        = q_rev;
   assign latch_led_out      = ext_lvl[`PIG_EXT_LATCH];
   assign halt_led_out       = ext_lvl[`PIG_EXT_HALT];
   assign clear_led_out      = ext_lvl[`PIG_EXT_CLEAR];
   // the rack must supply the clock; the module cannot make it
   assign shared_clk_led_out = st_q.shared_rack_clock_seen;
   assign irq_out            = |(st_q.evt & st_q.mask);

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!reset_n_in);

   property p_ro_keep;
      (wr_in && mapped && (idx == `PIG_IDX_CNT_LO || idx == `PIG_IDX_CNT_HI)
         && !q_step && !ext_fire[`PIG_EXT_CLEAR])
         |=> (st_q.count == $past(st_q.count));
   endproperty
   a_ro_keep : assert property (p_ro_keep)
      else $error("counter changed on a bus write");

   property p_ro_error;
      (wr_in && mapped && (idx == `PIG_IDX_CNT_LO || idx == `PIG_IDX_CNT_HI
         || idx == `PIG_IDX_LIVE))
         |=> (bus_error_out && rdata_out == 16'h0000);
   endproperty
   a_ro_error : assert property (p_ro_error)
      else $error("write to read-only register gave no bus error");

   property p_window;
      ((rd_in || wr_in) && !mapped) |=> bus_error_out;
   endproperty
   a_window : assert property (p_window)
      else $error("access outside the eight registers was not refused");

   property p_shared_rack_clock_on;
      shared_rack_clock_edge |=> shared_clk_led_out [*8];
   endproperty
   a_shared_rack_clock_on : assert property (p_shared_rack_clock_on)
      else $error("shared clock indicator dark while clock toggles");

   property p_shared_rack_clock_off;
      (st_q.shared_rack_clock_cnt == 16'h0000 && !shared_rack_clock_edge) |=> !shared_clk_led_out;
   endproperty
   a_shared_rack_clock_off : assert property (p_shared_rack_clock_off)
      else $error("shared clock indicator lit without clock");

   property p_ext_led;
      latch_in [*3] ##0 $past(reset_n_in, 2) |-> latch_led_out;
   endproperty
   a_ext_led : assert property (p_ext_led)
      else $error("latch indicator does not follow its input");

   property p_pol_edge;
      (st_q.evt == 3'h0
         && ext_lvl[`PIG_EXT_LATCH] != st_q.ext_prev[`PIG_EXT_LATCH]
         && (ext_lvl[`PIG_EXT_LATCH] != st_q.cfg[`PIG_CFG_POL_LATCH])
         && !(rd_in && mapped && idx == `PIG_IDX_EVT))
         |=> st_q.evt[`PIG_EXT_LATCH];
   endproperty
   a_pol_edge : assert property (p_pol_edge)
      else $error("latch edge of selected polarity missed");

   property p_evt_lock;
      (st_q.evt != 3'h0) |=> ((st_q.evt & ~$past(st_q.evt)) == 3'h0);
   endproperty
   a_evt_lock : assert property (p_evt_lock)
      else $error("new event accepted while a flag was pending");

   property p_reset_zero;
      $rose(reset_n_in) |-> (st_q.count == 24'h00_0000 && st_q.cfg == 16'h0000
         && st_q.evt == 3'h0 && !irq_out);
   endproperty
   a_reset_zero : assert property (p_reset_zero)
      else $error("register not zero after reset");

   // indicators trail the pins by the two synchroniser flops
   property p_led_track;
      $past(reset_n_in, 2) |-> ({clear_led_out, halt_led_out, latch_led_out}
         == $past({clear_in, halt_in, latch_in}, 2));
   endproperty
   a_led_track : assert property (p_led_track)
      else $error("input indicators do not trail their pins by two cycles");

   property p_idle_quiet;
      !(rd_in || wr_in) |=> (!bus_error_out && rdata_out == 16'h0000);
   endproperty
   a_idle_quiet : assert property (p_idle_quiet)
      else $error("bus error or read data without an access");

   property p_wr_ok;
      (wr_in && mapped && idx != `PIG_IDX_CNT_LO && idx != `PIG_IDX_CNT_HI
         && idx != `PIG_IDX_LIVE) |=> !bus_error_out;
   endproperty
   a_wr_ok : assert property (p_wr_ok)
      else $error("write to a writable register was refused");

   property p_rd_ok;
      (rd_in && mapped) |=> !bus_error_out;
   endproperty
   a_rd_ok : assert property (p_rd_ok)
      else $error("read inside the eight registers was refused");

   property p_cfg_store;
      (wr_in && mapped && idx == `PIG_IDX_CFG) |=> (st_q.cfg == $past(wdata_in));
   endproperty
   a_cfg_store : assert property (p_cfg_store)
      else $error("configuration word not stored");

   property p_clear_edge;
      ext_fire[`PIG_EXT_CLEAR] |=> (st_q.count == 24'h00_0000);
   endproperty
   a_clear_edge : assert property (p_clear_edge)
      else $error("active clear edge did not zero the count");

   property p_halt_level;
      (halt_act && !ext_fire[`PIG_EXT_CLEAR]) |=> (st_q.count == $past(st_q.count));
   endproperty
   a_halt_level : assert property (p_halt_level)
      else $error("count moved while halt was active");

   property p_rev_led;
      (q_step && !q_up) |-> (rev_led_out && !fwd_led_out);
   endproperty
   a_rev_led : assert property (p_rev_led)
      else $error("reverse step did not light only the reverse indicator");

   property p_evt_hold;
      (st_q.evt != 3'h0 && !rd_in && !wr_in) |=> (st_q.evt == $past(st_q.evt));
   endproperty
   a_evt_hold : assert property (p_evt_hold)
      else $error("pending event flag changed without software");

   property p_evt_read;
      (st_q.evt != 3'h0 && rd_in && mapped && idx == `PIG_IDX_EVT)
         |=> (st_q.evt == 3'h0 && !irq_out);
   endproperty
   a_evt_read : assert property (p_evt_read)
      else $error("reading the event flags left one pending");

   c_fwd    : cover property (q_step && q_up ##1 fwd_led_out);
   c_berr   : cover property (wr_in && mapped && idx == `PIG_IDX_CNT_LO ##1 bus_error_out);
   c_evt    : cover property (st_q.evt != 3'h0 && irq_out ##[1:8] rd_in);
   c_rev    : cover property (q_step && !q_up ##1 rev_led_out);
   c_shared_rack_clock   : cover property (shared_clk_led_out ##1 !shared_clk_led_out);

endmodule : pig_top

// File: verification/pig_rack_model.sv
// rack-side stand-in: shared backplane clock and quadrature pulse source
`timescale 1ns/1ps
module pig_rack_model (
   input  wire logic clk_in,
   input  wire logic reset_n_in,
   input  wire logic shared_rack_clock_en_in,
   input  wire logic step_in,
   input  wire logic swap_in,
   output logic      shared_rack_clock_out,
   output logic      phase_a_out,
   output logic      phase_b_out
);
   logic [1:0] div_q;
   logic [1:0] pos_q;
   logic       a;
   logic       b;

   // clock holds its last level while the rack does not carry it
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         div_q                 <= 2'h0;
         shared_rack_clock_out <= 1'b0;
      end
      else if (shared_rack_clock_en_in)
      begin
         div_q <= div_q + 2'h1;
         if (div_q == 2'h3)
            shared_rack_clock_out <= !shared_rack_clock_out;
      end
   end

   // one gray step per request; a leads b when not swapped
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         pos_q <= 2'h0;
      else if (step_in)
         pos_q <= pos_q + 2'h1;
   end

   assign a           = pos_q[1] ^ pos_q[0];
   assign b           = pos_q[1];
   assign phase_a_out = swap_in ? b : a;
   assign phase_b_out = swap_in ? a : b;
endmodule : pig_rack_model

// File: verification/pig_top_test.sv
// self-checking bench: register guard, indicators, events, shared clock
`timescale 1ns/1ps
`include "pig_consts.svh"
module pig_top_test;
   logic        clk;
   logic        rst_n;
   logic [7:0]  addr;
   logic [15:0] wdata;
   logic        wr;
   logic        rd;
   logic [15:0] rdata;
   logic        berr;
   logic [2:0]  ext;
   logic [2:0]  leds;
   logic        shared_rack_clock_en;
   logic        step;
   logic        swap;
   logic        pa;
   logic        pb;
   logic        shared_rack_clock;
   logic        fwd;
   logic        rev;
   logic        shared_rack_clock_led;
   logic        irq;
   logic [15:0] got;
   logic        be;
   logic [2:0]  ro_i [3] = '{3'h0, 3'h1, 3'h3};
   logic [2:0]  rw_i [4] = '{3'h2, 3'h4, 3'h5, 3'h6};
   logic [15:0] rw_v [4] = '{16'h0005, 16'hA5C3, 16'h5A3C, 16'h0F0F};
   int          err_total;
   int          checks;
   int          cyc;

   initial
   begin
      clk = 1'b0;
      forever #25 clk = !clk;
   end

   pig_top #(.DIR_HOLD_NS(500)) u_dut (
      .clk_in(clk), .reset_n_in(rst_n), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .bus_error_out(berr),
      .phase_a_in(pa), .phase_b_in(pb), .latch_in(ext[0]), .halt_in(ext[1]),
      .clear_in(ext[2]), .shared_rack_clock_in(shared_rack_clock), .fwd_led_out(fwd),
      .rev_led_out(rev), .latch_led_out(leds[0]), .halt_led_out(leds[1]),
      .clear_led_out(leds[2]), .shared_clk_led_out(shared_rack_clock_led), .irq_out(irq)
   );

   pig_rack_model u_rack (
      .clk_in(clk), .reset_n_in(rst_n), .shared_rack_clock_en_in(shared_rack_clock_en), .step_in(step),
      .swap_in(swap), .shared_rack_clock_out(shared_rack_clock), .phase_a_out(pa),
      .phase_b_out(pb)
   );

   function automatic logic [7:0] ad(input logic [2:0] i);
      return {3'h0, i, 2'h0};
   endfunction : ad

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : summarize

   task automatic cmp_w(input logic [15:0] g, input logic [15:0] e);
      checks++;
      if (g !== e)
      begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : cmp_w

   task automatic cmp_b(input logic g, input logic e);
      checks++;
      if (g !== e)
      begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : cmp_b

   // one bus access; read data and error taken in the answer cycle
   task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= w;
      rd    <= !w;
      @(posedge clk);
      wr    <= 1'b0;
      rd    <= 1'b0;
      #1;
      got = rdata;
      be  = berr;
   endtask : acc

   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wt

   task automatic steps(input int n);
      repeat (n)
      begin
         @(posedge clk);
         step <= 1'b1;
         @(posedge clk);
         step <= 1'b0;
         repeat (2) @(posedge clk);
      end
   endtask : steps

   task automatic pin(input int i, input logic v);
      @(posedge clk);
      ext[i] <= v;
   endtask : pin

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 6000)
      begin
         err_total++;
         summarize();
      end
   end

   initial
   begin
      rst_n   = 1'b0;
      addr    = 8'h00;
      wdata   = 16'h0000;
      wr      = 1'b0;
      rd      = 1'b0;
      ext     = 3'h0;
      shared_rack_clock_en = 1'b0;
      step    = 1'b0;
      swap    = 1'b0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         acc(1'b0, ad(3'(i)), 16'h0000);
         cmp_w(got, 16'h0000);
      end
      $display("test reset values done");
      foreach (ro_i[i])
      begin
         acc(1'b1, ad(ro_i[i]), 16'hFFFF);
         cmp_b(be, 1'b1);
         acc(1'b0, ad(ro_i[i]), 16'h0000);
         cmp_w(got, 16'h0000);
      end
      foreach (rw_i[i])
      begin
         acc(1'b1, ad(rw_i[i]), rw_v[i]);
         cmp_b(be, 1'b0);
         acc(1'b0, ad(rw_i[i]), 16'h0000);
         cmp_w(got, rw_v[i]);
      end
      acc(1'b1, ad(`PIG_IDX_CFG), 16'h0000);
      acc(1'b0, 8'h20, 16'h0000);
      cmp_b(be, 1'b1);
      cmp_w(got, 16'h0000);
      acc(1'b1, 8'h09, 16'h0001);
      cmp_b(be, 1'b1);
      $display("test register guard done");
      shared_rack_clock_en <= 1'b1;
      wt(40);
      cmp_b(shared_rack_clock_led, 1'b1);
      acc(1'b0, ad(`PIG_IDX_LIVE), 16'h0000);
      cmp_w(got, 16'h0020);
      @(posedge clk);
      shared_rack_clock_en <= 1'b0;
      wt(150);
      cmp_b(shared_rack_clock_led, 1'b1);
      wt(80);
      cmp_b(shared_rack_clock_led, 1'b0);
      $display("test shared clock done");
      steps(8);
      wt(2);
      cmp_b(fwd, 1'b1);
      cmp_b(rev, 1'b0);
      acc(1'b0, ad(`PIG_IDX_CNT_LO), 16'h0000);
      cmp_w(got, 16'h0008);
      wt(30);
      cmp_b(fwd, 1'b0);
      @(posedge clk);
      swap <= 1'b1;
      steps(8);
      wt(2);
      cmp_b(rev, 1'b1);
      cmp_b(fwd, 1'b0);
      acc(1'b0, ad(`PIG_IDX_CNT_LO), 16'h0000);
      cmp_w(got, 16'h0000);
      $display("test quadrature done");
      acc(1'b1, ad(`PIG_IDX_MASK), 16'h0007);
      pin(0, 1'b1);
      wt(1);
      cmp_b(leds[0], 1'b0);
      wt(5);
      cmp_b(leds[0], 1'b1);
      cmp_b(irq, 1'b1);
      pin(1, 1'b1);
      wt(6);
      acc(1'b0, ad(`PIG_IDX_EVT), 16'h0000);
      cmp_w(got, 16'h0001);
      wt(1);
      cmp_b(irq, 1'b0);
      pin(1, 1'b0);
      pin(0, 1'b0);
      wt(6);
      acc(1'b0, ad(`PIG_IDX_EVT), 16'h0000);
      cmp_w(got, 16'h0000);
      $display("test events done");
      for (int i = 0; i < 3; i++)
      begin
         acc(1'b1, ad(`PIG_IDX_CFG), 16'h1000 << i);
         pin(i, 1'b1);
         wt(6);
         cmp_b(leds[i], 1'b1);
         acc(1'b0, ad(`PIG_IDX_EVT), 16'h0000);
         cmp_w(got, 16'h0000);
         pin(i, 1'b0);
         wt(6);
         cmp_b(leds[i], 1'b0);
         acc(1'b0, ad(`PIG_IDX_EVT), 16'h0000);
         cmp_w(got, 16'h0001 << i);
      end
      $display("test polarity done");
      summarize();
   end
endmodule : pig_top_test
